/* File: verilog/iilm_pkg.sv */
// Shared constants and types for the integer issue latency model
`default_nettype none
package iilm_pkg;

    // Instruction forms presented by the front end
    typedef enum logic [4:0] {
        FORM_MUL8_REG = 5'h00,
        FORM_MUL16_REG = 5'h01,
        FORM_MUL32_REG = 5'h02,
        FORM_MUL64_REG = 5'h03,
        FORM_MUL8_MEM = 5'h04,
        FORM_MUL16_MEM1 = 5'h05,
        FORM_MUL16_MEM2 = 5'h06,
        FORM_MUL32_MEM = 5'h07,
        FORM_MUL64_MEM1 = 5'h08,
        FORM_MUL64_MEM2 = 5'h09,
        FORM_LEA2 = 5'h0a,
        FORM_LEA3 = 5'h0b,
        FORM_JMP_FAR = 5'h0c,
        FORM_LWP = 5'h0d,
        FORM_ALU_REG = 5'h0e,
        FORM_ALU_MEM = 5'h0f,
        FORM_FLAGS_LOAD = 5'h10,
        FORM_LZCNT_MEM = 5'h11
    } form_e;

    // Decode classes
    typedef enum logic [1:0] {
        DEC_SINGLE = 2'h0,
        DEC_DOUBLE = 2'h1,
        DEC_MICRO = 2'h2
    } decode_e;

    // Pipe classes chosen by the table
    typedef enum logic [1:0] {
        PC_EITHER_INT = 2'h0,
        PC_INT_B = 2'h1,
        PC_AGEN_INT = 2'h2,
        PC_SEQ = 2'h3
    } pipe_class_e;

    // Hold stage states
    typedef enum logic [1:0] {
        HOLD_EMPTY = 2'b01,
        HOLD_FULL = 2'b10
    } hold_e;

    // Pipe mask bits
    localparam logic [3:0] PIPE_INT_A = 4'h1;
    localparam logic [3:0] PIPE_INT_B = 4'h2;
    localparam logic [3:0] PIPE_AGEN_A = 4'h4;
    localparam logic [3:0] PIPE_AGEN_B = 4'h8;
    localparam logic [3:0] PIPE_NONE = 4'h0;

    // Latencies and repeat intervals in core clock cycles
    localparam logic [3:0] LAT_NONE = 4'h0;
    localparam logic [3:0] LAT_ONE = 4'h1;
    localparam logic [3:0] LAT_LEA3 = 4'h2;
    localparam logic [3:0] LAT_MUL_REG = 4'h4;
    localparam logic [3:0] LAT_MUL64_REG = 4'h6;
    localparam logic [3:0] LAT_MUL_MEM = 4'h8;
    localparam logic [3:0] LAT_MUL64_MEM = 4'ha;
    localparam logic [3:0] LAT_ALU_MEM = 4'h5;
    localparam logic [3:0] LAT_FLAGS_LOAD = 4'h4;
    localparam logic [3:0] LAT_LZCNT_MEM = 4'h6;
    localparam logic [3:0] REP_MUL = 4'h2;
    localparam logic [3:0] REP_MUL64 = 4'h4;

    // Reset values
    localparam logic [3:0] COUNT_RESET = 4'h0;
    localparam logic [1:0] RST_SYNC_RESET = 2'h0;

    // Register file size
    localparam int NUM_REGS = 16;

endpackage
`default_nettype wire

/* File: verilog/decode_if.sv */
// Carrier between the issue logic and the decode attribute table
`timescale 1ns/1ns
`default_nettype none
interface decode_if;
    iilm_pkg::form_e form;
    iilm_pkg::decode_e decodeType;
    iilm_pkg::pipe_class_e pipeClass;
    logic [3:0] latency;
    logic [3:0] repeatGap;
    logic isMul;

    modport table_side (input form, output decodeType, pipeClass, latency, repeatGap, isMul);
    modport user_side (output form, input decodeType, pipeClass, latency, repeatGap, isMul);
endinterface
`default_nettype wire

/* File: verilog/decode_table.sv */
// Attribute table: decode class, pipe class, latency and repeat per form
`timescale 1ns/1ns
`default_nettype none
module decode_table (
    // Lookup
    decode_if.table_side dec
);
    always_comb begin
        dec.decodeType = iilm_pkg::DEC_SINGLE;
        dec.pipeClass = iilm_pkg::PC_INT_B;
        dec.latency = iilm_pkg::LAT_NONE;
        dec.repeatGap = iilm_pkg::LAT_NONE;
        dec.isMul = 1'b1;
        unique case (dec.form)
            iilm_pkg::FORM_MUL8_REG, iilm_pkg::FORM_MUL32_REG: begin
                dec.latency = iilm_pkg::LAT_MUL_REG;
                dec.repeatGap = iilm_pkg::REP_MUL;
            end
            iilm_pkg::FORM_MUL16_REG: begin
                dec.decodeType = iilm_pkg::DEC_DOUBLE;
                dec.latency = iilm_pkg::LAT_MUL_REG;
                dec.repeatGap = iilm_pkg::REP_MUL;
            end
            iilm_pkg::FORM_MUL64_REG: begin
                dec.latency = iilm_pkg::LAT_MUL64_REG;
                dec.repeatGap = iilm_pkg::REP_MUL64;
            end
            iilm_pkg::FORM_MUL8_MEM, iilm_pkg::FORM_MUL16_MEM1, iilm_pkg::FORM_MUL32_MEM: begin
                dec.latency = iilm_pkg::LAT_MUL_MEM;
                dec.repeatGap = iilm_pkg::REP_MUL;
            end
            iilm_pkg::FORM_MUL16_MEM2: begin
                dec.decodeType = iilm_pkg::DEC_DOUBLE;
                dec.latency = iilm_pkg::LAT_MUL_MEM;
                dec.repeatGap = iilm_pkg::REP_MUL;
            end
            iilm_pkg::FORM_MUL64_MEM1: begin
                dec.latency = iilm_pkg::LAT_MUL_MEM;
                dec.repeatGap = iilm_pkg::REP_MUL64;
            end
            iilm_pkg::FORM_MUL64_MEM2: begin
                dec.latency = iilm_pkg::LAT_MUL64_MEM;
                dec.repeatGap = iilm_pkg::REP_MUL64;
            end
            iilm_pkg::FORM_LEA2, iilm_pkg::FORM_ALU_REG: begin
                dec.isMul = 1'b0;
                dec.pipeClass = iilm_pkg::PC_EITHER_INT;
                dec.latency = iilm_pkg::LAT_ONE;
            end
            iilm_pkg::FORM_LEA3: begin
                dec.isMul = 1'b0;
                dec.decodeType = iilm_pkg::DEC_DOUBLE;
                dec.pipeClass = iilm_pkg::PC_AGEN_INT;
                dec.latency = iilm_pkg::LAT_LEA3;
            end
            iilm_pkg::FORM_ALU_MEM: begin
                dec.isMul = 1'b0;
                dec.pipeClass = iilm_pkg::PC_EITHER_INT;
                dec.latency = iilm_pkg::LAT_ALU_MEM;
            end
            iilm_pkg::FORM_FLAGS_LOAD: begin
                dec.isMul = 1'b0;
                dec.pipeClass = iilm_pkg::PC_EITHER_INT;
                dec.latency = iilm_pkg::LAT_FLAGS_LOAD;
            end
            iilm_pkg::FORM_LZCNT_MEM: begin
                dec.isMul = 1'b0;
                dec.decodeType = iilm_pkg::DEC_DOUBLE;
                dec.pipeClass = iilm_pkg::PC_EITHER_INT;
                dec.latency = iilm_pkg::LAT_LZCNT_MEM;
            end
            // Far jumps, profiling inserts and unknown codes go to the sequencer
            default: begin
                dec.isMul = 1'b0;
                dec.decodeType = iilm_pkg::DEC_MICRO;
                dec.pipeClass = iilm_pkg::PC_SEQ;
            end
        endcase
    end
endmodule
`default_nettype wire

/* File: verilog/integer_issue_latency_model.sv */
// Issue logic: holds one request, checks hazards, dispatches with its timing
`timescale 1ns/1ns
`default_nettype none
module integer_issue_latency_model (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Request from the front end
    input wire logic issueValid,
    input wire logic [4:0] issueForm,
    input wire logic [3:0] issueDest,
    input wire logic issueDestValid,
    input wire logic [3:0] issueSrcA,
    input wire logic issueSrcAValid,
    input wire logic [3:0] issueSrcB,
    input wire logic issueSrcBValid,
    output logic issueReady_r,
    // Sequencer completion
    input wire logic seqDone,
    // Dispatch
    output logic dispatchValid_r,
    output logic [4:0] dispatchForm_r,
    output logic [3:0] dispatchDest_r,
    output logic [3:0] dispatchPipes_r,
    output logic [1:0] dispatchDecode_r,
    output logic [3:0] dispatchLatency_r,
    output logic dispatchIsMul_r,
    // State
    output logic seqBusy_r,
    output logic [15:0] regBusy_r
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] rstSync_r;
    logic rstN;
    iilm_pkg::hold_e holdState_r;
    logic [4:0] holdForm_r;
    logic [3:0] holdDest_r, holdSrcA_r, holdSrcB_r;
    logic holdDestValid_r, holdSrcAValid_r, holdSrcBValid_r;
    logic [3:0] regCount_r [iilm_pkg::NUM_REGS];
    logic [3:0] mulCount_r;
    logic pipeToggle_r;
    logic take, fire, srcHazard, mulHazard;
    logic [3:0] pipes_nxt;
    logic [15:0] regBusy_nxt;
    decode_if dec ();

    // Release reset through two flops
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_r <= iilm_pkg::RST_SYNC_RESET;
        end else begin
            rstSync_r <= {rstSync_r[0], 1'b1};
        end
    end
    assign rstN = rstSync_r[1];

    decode_table table_u (
        .dec(dec)
    );
    assign dec.form = iilm_pkg::form_e'(holdForm_r);

    ////////////////////////////////////////////////////////////////////////////
    // Hazards are checked on the held copy so the front end sees a clean handshake
    assign take = issueValid && issueReady_r;
    assign srcHazard = (holdSrcAValid_r && regCount_r[holdSrcA_r] != iilm_pkg::COUNT_RESET)
        || (holdSrcBValid_r && regCount_r[holdSrcB_r] != iilm_pkg::COUNT_RESET);
    assign mulHazard = dec.isMul && mulCount_r != iilm_pkg::COUNT_RESET;
    // Sequencer work has no fixed end, so everything waits for its done strobe
    assign fire = holdState_r == iilm_pkg::HOLD_FULL && !srcHazard && !mulHazard && !seqBusy_r;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            holdState_r <= iilm_pkg::HOLD_EMPTY;
            issueReady_r <= 1'b0;
        end else begin
            unique case (holdState_r)
                iilm_pkg::HOLD_EMPTY: begin
                    if (take) begin
                        holdState_r <= iilm_pkg::HOLD_FULL;
                        issueReady_r <= 1'b0;
                    end else begin
                        issueReady_r <= 1'b1;
                    end
                end
                iilm_pkg::HOLD_FULL: begin
                    if (fire) begin
                        holdState_r <= iilm_pkg::HOLD_EMPTY;
                        issueReady_r <= 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            holdForm_r <= 5'h00;
            holdDest_r <= 4'h0;
            holdSrcA_r <= 4'h0;
            holdSrcB_r <= 4'h0;
            holdDestValid_r <= 1'b0;
            holdSrcAValid_r <= 1'b0;
            holdSrcBValid_r <= 1'b0;
        end else if (take) begin
            holdForm_r <= issueForm;
            holdDest_r <= issueDest;
            holdSrcA_r <= issueSrcA;
            holdSrcB_r <= issueSrcB;
            holdDestValid_r <= issueDestValid;
            holdSrcAValid_r <= issueSrcAValid;
            holdSrcBValid_r <= issueSrcBValid;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pipe choice; either-pipe work alternates to spread load
    always_comb begin
        pipes_nxt = iilm_pkg::PIPE_NONE;
        unique case (dec.pipeClass)
            iilm_pkg::PC_EITHER_INT: pipes_nxt = pipeToggle_r ? iilm_pkg::PIPE_INT_B : iilm_pkg::PIPE_INT_A;
            iilm_pkg::PC_INT_B: pipes_nxt = iilm_pkg::PIPE_INT_B;
            iilm_pkg::PC_AGEN_INT: pipes_nxt = pipeToggle_r ? (iilm_pkg::PIPE_AGEN_B | iilm_pkg::PIPE_INT_B)
                : (iilm_pkg::PIPE_AGEN_A | iilm_pkg::PIPE_INT_A);
            iilm_pkg::PC_SEQ: pipes_nxt = iilm_pkg::PIPE_NONE;
        endcase
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            pipeToggle_r <= 1'b0;
        end else if (fire && dec.pipeClass != iilm_pkg::PC_INT_B && dec.pipeClass != iilm_pkg::PC_SEQ) begin
            pipeToggle_r <= !pipeToggle_r;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            dispatchValid_r <= 1'b0;
            dispatchForm_r <= 5'h00;
            dispatchDest_r <= 4'h0;
            dispatchPipes_r <= iilm_pkg::PIPE_NONE;
            dispatchDecode_r <= iilm_pkg::DEC_SINGLE;
            dispatchLatency_r <= iilm_pkg::LAT_NONE;
            dispatchIsMul_r <= 1'b0;
        end else begin
            dispatchValid_r <= fire;
            if (fire) begin
                dispatchForm_r <= holdForm_r;
                dispatchDest_r <= holdDest_r;
                dispatchPipes_r <= pipes_nxt;
                dispatchDecode_r <= dec.decodeType;
                dispatchLatency_r <= dec.latency;
                dispatchIsMul_r <= dec.isMul;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer busy: a done in the same cycle as a new start leaves it busy
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            seqBusy_r <= 1'b0;
        end else if (fire && dec.decodeType == iilm_pkg::DEC_MICRO) begin
            seqBusy_r <= 1'b1;
        end else if (seqDone) begin
            seqBusy_r <= 1'b0;
        end
    end

    // Multiply repeat spacing: count holds gap minus one after a multiply issues
    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            mulCount_r <= iilm_pkg::COUNT_RESET;
        end else if (fire && dec.isMul) begin
            mulCount_r <= dec.repeatGap - 4'h1;
        end else if (mulCount_r != iilm_pkg::COUNT_RESET) begin
            mulCount_r <= mulCount_r - 4'h1;
        end
    end

    // Result scoreboard: a consumer may issue latency cycles after its producer
    for (genvar r = 0; r < iilm_pkg::NUM_REGS; r++) begin : g_score
        logic loadHere;
        assign loadHere = fire && holdDestValid_r && holdDest_r == 4'(r) && dec.latency != iilm_pkg::LAT_NONE;
        always_ff @(posedge clk or negedge rstN) begin
            if (!rstN) begin
                regCount_r[r] <= iilm_pkg::COUNT_RESET;
            end else if (loadHere) begin
                regCount_r[r] <= dec.latency - 4'h1;
            end else if (regCount_r[r] != iilm_pkg::COUNT_RESET) begin
                regCount_r[r] <= regCount_r[r] - 4'h1;
            end
        end
        assign regBusy_nxt[r] = loadHere ? (dec.latency > 4'h1) : (regCount_r[r] > 4'h1);
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            regBusy_r <= 16'h0000;
        end else begin
            regBusy_r <= regBusy_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sequence s_mul_gap2;
        dispatchValid_r && dispatchIsMul_r && dispatchForm_r inside {5'h00, 5'h01, 5'h02};
    endsequence
    sequence s_mul_gap4;
        dispatchValid_r && dispatchForm_r inside {5'h03, 5'h08, 5'h09};
    endsequence

    a_mul_reg_timing: assert property (@(posedge clk) disable iff (!rstN)
        s_mul_gap2 |-> dispatchPipes_r == 4'h2 && dispatchLatency_r == 4'h4 ##1 !(dispatchValid_r && dispatchIsMul_r))
        else $error("short multiply timing wrong");
    a_mul64_gap: assert property (@(posedge clk) disable iff (!rstN)
        s_mul_gap4 |-> dispatchPipes_r == 4'h2 ##1 !(dispatchValid_r && dispatchIsMul_r) [*3])
        else $error("wide multiply issued too soon");
    a_mul_mem_latency: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchForm_r inside {5'h05, 5'h06, 5'h07} |-> dispatchLatency_r == 4'h8
        && regBusy_r[dispatchDest_r] == 1'b1)
        else $error("memory multiply latency wrong");
    a_mul64_mem_latency: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r |-> (dispatchForm_r == 5'h09) == (dispatchLatency_r == 4'ha))
        else $error("wide memory multiply latency wrong");
    a_split_decode: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchIsMul_r |-> (dispatchDecode_r == 2'h1) == (dispatchForm_r inside {5'h01, 5'h06}))
        else $error("multiply decode class wrong");
    a_lea3_route: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchForm_r == 5'h0b |-> dispatchDecode_r == 2'h1 && dispatchLatency_r == 4'h2
        && (dispatchPipes_r & 4'hc) != 4'h0 && (dispatchPipes_r & 4'h3) != 4'h0)
        else $error("three part address load routed wrong");
    a_lea2_route: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchForm_r == 5'h0a |-> dispatchDecode_r == 2'h0 && dispatchLatency_r == 4'h1
        && $countones(dispatchPipes_r) == 1 && (dispatchPipes_r & 4'h3) != 4'h0)
        else $error("two part address load routed wrong");
    a_far_jump_seq: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchForm_r == 5'h0c |-> dispatchDecode_r == 2'h2 && seqBusy_r)
        else $error("far jump not sent to sequencer");
    a_seq_blocks: assert property (@(posedge clk) disable iff (!rstN)
        dispatchValid_r && dispatchForm_r == 5'h0d |-> dispatchDecode_r == 2'h2 ##1 !dispatchValid_r)
        else $error("issue during sequencer work");
    a_dep_hold: assert property (@(posedge clk) disable iff (!rstN)
        fire && holdSrcAValid_r |-> regCount_r[holdSrcA_r] == 4'h0 && !regBusy_r[holdSrcA_r])
        else $error("dependent op issued early");
endmodule
`default_nettype wire

/* File: tb/seq_model.sv */
// Sequencer partner model: answers each microcode dispatch with a one-cycle done pulse
`timescale 1ns/1ns
`default_nettype none
module seq_model (
    // Clock
    input wire logic clk,
    // Dispatch as seen by the sequencer
    input wire logic dispatchValid,
    input wire logic [1:0] dispatchDecode,
    // Cycles from dispatch to done, at least one
    input wire logic [7:0] doneDelay,
    // Completion
    output logic seqDone
);
    logic [7:0] left_r;

    initial begin
        seqDone = 1'b0;
        left_r = 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // No fixed run time exists, so each scenario picks a prompt or a slow answer
    always @(posedge clk) begin
        seqDone <= 1'b0;
        if (dispatchValid && dispatchDecode == iilm_pkg::DEC_MICRO) begin
            left_r <= doneDelay;
        end else if (left_r == 8'h01) begin
            seqDone <= 1'b1;
            left_r <= 8'h00;
        end else if (left_r != 8'h00) begin
            left_r <= left_r - 8'h01;
        end
    end
endmodule
`default_nettype wire

/* File: tb/integer_issue_latency_model_test.sv */
// Self-checking bench for the integer issue latency model
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(what, exp, got) \
    begin \
        cmpCount++; \
        if ((got) !== (exp)) begin \
            nFail++; \
            $display("ERROR %s expected %0h seen %0h", what, exp, got); \
        end \
    end
module integer_issue_latency_model_test;
    typedef struct {logic [4:0] p; logic [4:0] c; logic [1:0] dep; int gap;} pair_s;
    logic clk, reset_n, issueValid, issueDestValid, issueSrcAValid, issueSrcBValid, seqDone;
    logic [4:0] issueForm, dispatchForm_r;
    logic [3:0] issueDest, issueSrcA, issueSrcB, dispatchDest_r, dispatchPipes_r, dispatchLatency_r;
    logic issueReady_r, dispatchValid_r, dispatchIsMul_r, seqBusy_r;
    logic [1:0] dispatchDecode_r;
    logic [15:0] regBusy_r;
    logic [7:0] doneDelay;
    int nFail = 0, cmpCount = 0, cyc = 0, nFire = 0, lastCyc = 0, prevCyc = 0, doneCyc = 0;
    localparam logic [1:0] EXP_DEC [14] = '{2'h0, 2'h1, 2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0,
        2'h0, 2'h1, 2'h2, 2'h2};
    localparam logic [3:0] EXP_LAT [14] = '{4'h4, 4'h4, 4'h4, 4'h6, 4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'ha,
        4'h1, 4'h2, 4'h0, 4'h0};

    integer_issue_latency_model DUT (.clk(clk), .reset_n(reset_n), .issueValid(issueValid),
        .issueForm(issueForm), .issueDest(issueDest), .issueDestValid(issueDestValid),
        .issueSrcA(issueSrcA), .issueSrcAValid(issueSrcAValid), .issueSrcB(issueSrcB),
        .issueSrcBValid(issueSrcBValid), .issueReady_r(issueReady_r), .seqDone(seqDone),
        .dispatchValid_r(dispatchValid_r), .dispatchForm_r(dispatchForm_r), .dispatchDest_r(dispatchDest_r),
        .dispatchPipes_r(dispatchPipes_r), .dispatchDecode_r(dispatchDecode_r),
        .dispatchLatency_r(dispatchLatency_r), .dispatchIsMul_r(dispatchIsMul_r), .seqBusy_r(seqBusy_r),
        .regBusy_r(regBusy_r));
    seq_model seqPartner (.clk(clk), .dispatchValid(dispatchValid_r), .dispatchDecode(dispatchDecode_r),
        .doneDelay(doneDelay), .seqDone(seqDone));

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Fire and done times are kept by edge count so gaps never depend on process order
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (dispatchValid_r === 1'b1) begin
            prevCyc = lastCyc;
            lastCyc = cyc;
            nFire++;
        end
        if (seqDone === 1'b1) doneCyc = cyc;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Request is held until the edge that samples ready high
    task automatic issue(input logic [4:0] f, input logic [3:0] d, input logic [3:0] s, input logic [1:0] use_);
        int k;
        @(posedge clk);
        #1;
        issueValid = 1'b1;
        issueForm = f;
        issueDest = d;
        issueDestValid = 1'b1;
        issueSrcA = s;
        issueSrcAValid = use_[0];
        issueSrcB = s;
        issueSrcBValid = use_[1];
        k = 0;
        while (issueReady_r !== 1'b1 && k < 300) begin
            @(posedge clk);
            #1;
            k++;
        end
        @(posedge clk);
        #1;
        issueValid = 1'b0;
    endtask

    task automatic wait_fire(input int target);
        int k;
        for (k = 0; k < 300 && nFire < target; k++) begin
            @(posedge clk);
            #2;
        end
        `CHECK_EQ("dispatch count", target, nFire)
    endtask

    task automatic t_table();
        int i;
        for (i = 0; i < 14; i++) begin
            issue(5'(i), 4'h7, 4'h0, 2'b00);
            wait_fire(nFire + 1);
            `CHECK_EQ("form", 5'(i), dispatchForm_r)
            `CHECK_EQ("dest", 4'h7, dispatchDest_r)
            `CHECK_EQ("decode class", EXP_DEC[i], dispatchDecode_r)
            `CHECK_EQ("latency", EXP_LAT[i], dispatchLatency_r)
            `CHECK_EQ("multiply flag", (i <= 9), dispatchIsMul_r)
            if (i <= 9) `CHECK_EQ("mul pipe", iilm_pkg::PIPE_INT_B, dispatchPipes_r)
            if (i == 10) `CHECK_EQ("two-part pipe", 1'b1, dispatchPipes_r === 4'h1 || dispatchPipes_r === 4'h2)
            if (i == 11) `CHECK_EQ("three-part pipes", 1'b1, dispatchPipes_r === 4'h5 || dispatchPipes_r === 4'ha)
            if (i >= 12) `CHECK_EQ("sequencer busy", 1'b1, seqBusy_r)
        end
        $display("test table done");
    endtask

    // Producer then consumer: dep bit0 uses source a, bit1 source b
    task automatic t_spacing();
        pair_s pr [12];
        int i;
        int base;
        pr = '{'{5'h03, 5'h00, 2'h0, 4}, '{5'h00, 5'h01, 2'h0, 2}, '{5'h07, 5'h02, 2'h0, 2},
            '{5'h09, 5'h05, 2'h0, 4}, '{5'h08, 5'h02, 2'h0, 4}, '{5'h09, 5'h0e, 2'h1, 10},
            '{5'h06, 5'h0e, 2'h2, 8}, '{5'h03, 5'h0e, 2'h1, 6}, '{5'h0b, 5'h0e, 2'h1, 2},
            '{5'h10, 5'h0e, 2'h2, 4}, '{5'h03, 5'h0e, 2'h0, 2}, '{5'h0f, 5'h11, 2'h1, 5}};
        for (i = 0; i < 12; i++) begin
            // The producer fires before the consumer call returns, so count from here
            base = nFire;
            issue(pr[i].p, 4'h3, 4'h0, 2'b00);
            issue(pr[i].c, 4'h5, 4'h3, pr[i].dep);
            if (pr[i].gap >= 4 && pr[i].dep != 2'h0) `CHECK_EQ("result busy", 1'b1, regBusy_r[3])
            wait_fire(base + 2);
            `CHECK_EQ("issue gap", pr[i].gap, lastCyc - prevCyc)
            repeat (12) @(posedge clk);
            `CHECK_EQ("scoreboard clear", 16'h0000, regBusy_r)
        end
        $display("test spacing done");
    endtask

    // Slow then prompt sequencer; nothing may pass while it owns issue
    task automatic t_micro();
        int i;
        int base;
        for (i = 0; i < 2; i++) begin
            doneDelay = (i == 0) ? 8'h0c : 8'h01;
            base = nFire;
            issue((i == 0) ? 5'h0c : 5'h0d, 4'h2, 4'h0, 2'b00);
            issue(5'h00, 4'h4, 4'h0, 2'b00);
            if (i == 0) `CHECK_EQ("held by sequencer", 1'b1, seqBusy_r)
            wait_fire(base + 2);
            `CHECK_EQ("fire after done", 1'b1, lastCyc > doneCyc && lastCyc <= doneCyc + 3)
            `CHECK_EQ("sequencer free", 1'b0, seqBusy_r)
        end
        $display("test micro done");
    endtask

    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        reset_n = 1'b0;
        issueValid = 1'b0;
        issueForm = 5'h00;
        issueDest = 4'h0;
        issueDestValid = 1'b0;
        issueSrcA = 4'h0;
        issueSrcAValid = 1'b0;
        issueSrcB = 4'h0;
        issueSrcBValid = 1'b0;
        doneDelay = 8'h03;
        repeat (16) @(posedge clk);
        #1;
        reset_n = 1'b1;
        repeat (4) @(posedge clk);
        #1;
        `CHECK_EQ("ready after reset", 1'b1, issueReady_r)
        `CHECK_EQ("idle after reset", 1'b0, dispatchValid_r | seqBusy_r | (|regBusy_r))
        t_table();
        t_spacing();
        t_micro();
        closeOut();
    end

    // Whole run needs well under 3000 cycles
    initial begin
        repeat (20000) @(posedge clk);
        nFail++;
        $display("ERROR watchdog expected 0 seen 1");
        closeOut();
    end
endmodule
`default_nettype wire
